// >>> common/clock_ctl_pkg.sv
// Purpose: Shared constants and types for the static clock stop/start/reset block
// Assumes: One core clock; all pins arrive asynchronously
// Notes:   Phase numbering covers both halves of each source cycle
package clock_ctl_pkg;

   // Oscillator cycles counted before a crystal restart releases the clocks
   localparam int OSC_START_COUNT_DEF = 8192;
   localparam int OSC_COUNT_MIN_W     = 13;

   // Processor clock periods the reset output outlives its cause
   localparam int RESET_HOLD_CYCLES = 16;
   localparam int HOLD_W            = 5;

   // Six half-phases of the source per processor clock period
   localparam logic [2:0] PH_FALL     = 3'h0;
   localparam logic [2:0] PH_HALF_UP  = 3'h3;
   localparam logic [2:0] PH_RISE     = 3'h4;
   localparam logic [2:0] PH_LAST     = 3'h5;

   // Extra processor clock rises run after a stop code
   localparam logic [1:0] STOP_TRAIL_RISES = 2'h2;

   typedef struct packed
   {
      logic stop_n;
      logic mid;
      logic low;
   } halt_status_s;

   localparam halt_status_s STATUS_PASSIVE = 3'h7;
   localparam halt_status_s STATUS_STOP    = 3'h3;

   typedef enum logic [1:0]
   {
      ST_RUN,
      ST_STOP_WAIT,
      ST_STOPPED,
      ST_OSC_COUNT
   } clk_state_e;

endpackage

// >>> logic/pin_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pins
// Assumes: Inputs are quasi-static relative to core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync
#(
   parameter int          WIDTH     = 1,
   parameter logic [31:0] RESET_VAL = 32'h0
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] meta;

   initial
   begin
      if (WIDTH < 1 || WIDTH > 32)
         $error("pin_sync WIDTH out of range");
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         meta   <= RESET_VAL[WIDTH-1:0];
         synced <= RESET_VAL[WIDTH-1:0];
      end
      else
      begin
         meta   <= pin;
         synced <= meta;
      end
   end

endmodule

// >>> logic/clock_phase_gen.sv
// Purpose: Divide-by-three phase walker for the processor clocks
// Assumes: half_tick marks each edge of the frequency source
// Notes:   Holding run low freezes the phase, so outputs stop without runts
`timescale 1ns/10ps
module clock_phase_gen
   import clock_ctl_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       half_tick,
   input  wire logic       run,
   output logic      [2:0] phase,
   output logic            rise_evt,
   output logic            fall_evt
);

   logic [2:0] next_phase;

   always_comb
   begin
      next_phase = (phase == PH_LAST) ? PH_FALL : phase + 3'h1;
      rise_evt   = half_tick && run && (next_phase == PH_RISE);
      fall_evt   = half_tick && run && (next_phase == PH_FALL);
   end

   // Power-on parks in the high phase, as a stopped clock does
   always_ff @(posedge core_clk)
   begin
      if (rst)
         phase <= PH_RISE;
      else if (half_tick && run)
         phase <= next_phase;
   end

endmodule

// >>> logic/clock_stop_start.sv
// Purpose: Start, stop and reset control for a static clock generator
// Assumes: Sources and pins are slow against core_clk and are resampled
// Notes:   Source edges become half-phase ticks; clocks are flops in core_clk
//
// What this block does
// - Reset request is resampled on each processor clock falling edge.
// - Low reset request drives cpu reset output high in both source modes.
// - Low reset request restarts an idle oscillator.
// - Reset output stays high sixteen processor clocks after request rises.
// - A reset during a running oscillator count leaves that count untouched.
// - After the restart count completes, reset stays high sixteen more clocks.
// - Reset output stays high while the reset request stays low.
// - From power-on or stop, start high or reset low begins restart.
// - External source mode restarts right after request synchronisation, no count.
// - Crystal mode restarts the oscillator and holds clocks until 8192 cycles.
// - Start during a stopped oscillator also runs the 8192-cycle count.
// - Clocks restart cleanly in phase, without runt pulses.
// - Status inputs are sampled on each processor clock rising edge.
// - Status low-high-high at a rising edge triggers a stop.
// - Stop code counts only after all-high status at previous rising edge.
// - After stop, processor clocks run two more cycles and halt high.
// - Peripheral clock freezes at its present level on stop.
// - Stopping behaves identically in slow and fast modes.
// - Crystal mode stop also stops the oscillator.
// - External source mode stop keeps the oscillator running.
// - With oscillator stopped, clocks stay high until request ends and count completes.
`timescale 1ns/10ps
module clock_stop_start
   import clock_ctl_pkg::*;
#(
   parameter int OSC_START_COUNT = OSC_START_COUNT_DEF
)
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic reset_request_n,
   input  wire logic start,
   input  wire logic freq_source_select,
   input  wire logic crystal_in,
   input  wire logic external_freq_input,
   input  wire logic halt_status_or_stop_n,
   input  wire logic halt_status_mid,
   input  wire logic halt_status_low,
   output logic      cpu_clock,
   output logic      half_duty_clock,
   output logic      peripheral_clock,
   output logic      crystal_buffer_out,
   output logic      osc_enable,
   output logic      cpu_reset_out
);

   localparam int OSC_W = ($clog2(OSC_START_COUNT + 1) < OSC_COUNT_MIN_W) ?
                          OSC_COUNT_MIN_W : $clog2(OSC_START_COUNT + 1);
   localparam logic [OSC_W-1:0] OSC_FULL = OSC_W'(OSC_START_COUNT);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESET_HOLD_CYCLES);
   localparam logic [HOLD_W-1:0] HOLD_ONE  = 5'h01;

   initial
   begin
      if (OSC_START_COUNT < 1)
         $error("OSC_START_COUNT must be at least one");
      if (RESET_HOLD_CYCLES >= (1 << HOLD_W))
         $error("Reset hold count does not fit its counter");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   logic         reset_req_n_s;
   logic         start_s;
   logic         fss_s;
   logic         crystal_s;
   logic         efi_s;
   halt_status_s status_s;
   halt_status_s status_pins;

   assign status_pins = {halt_status_or_stop_n, halt_status_mid, halt_status_low};

   pin_sync #(.WIDTH(2), .RESET_VAL(32'h1)) u_req_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      ({start, reset_request_n}),
      .synced   ({start_s, reset_req_n_s})
   );

   pin_sync #(.WIDTH(3), .RESET_VAL(32'h0)) u_src_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      ({freq_source_select, crystal_in, external_freq_input}),
      .synced   ({fss_s, crystal_s, efi_s})
   );

   // Resting status is passive, so a stop cannot follow reset at once
   pin_sync #(.WIDTH(3), .RESET_VAL(32'h7)) u_status_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pin      (status_pins),
      .synced   (status_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Source edge detection

   clk_state_e state;
   logic       osc_run;
   logic       crystal_prev;
   logic       efi_prev;
   logic       crystal_rise;
   logic       src_tick;
   logic       run;
   logic       restart_req;
   logic       restart_pending;
   logic       osc_done;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         crystal_prev <= 1'b0;
         efi_prev     <= 1'b0;
      end
      else
      begin
         crystal_prev <= crystal_s;
         efi_prev     <= efi_s;
      end
   end

   // A stopped crystal yields no edges, whatever the pin shows
   assign osc_enable   = osc_run || fss_s;
   assign crystal_rise = osc_enable && crystal_s && !crystal_prev;
   assign src_tick     = fss_s ? (efi_s != efi_prev) :
                                 (osc_enable && (crystal_s != crystal_prev));

   assign run         = (state == ST_RUN) || (state == ST_STOP_WAIT);
   assign restart_req = start_s || !reset_req_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // Clock phase and outputs

   logic [2:0] phase;
   logic       rise_evt;
   logic       fall_evt;

   // Freezing the walker, never forcing it, keeps restarts free of runts
   clock_phase_gen u_phase
   (
      .core_clk  (core_clk),
      .rst       (rst),
      .half_tick (src_tick),
      .run       (run),
      .phase     (phase),
      .rise_evt  (rise_evt),
      .fall_evt  (fall_evt)
   );

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cpu_clock       <= 1'b1;
         half_duty_clock <= 1'b1;
      end
      else
      begin
         cpu_clock       <= (phase >= PH_RISE);
         half_duty_clock <= (phase >= PH_HALF_UP);
      end
   end

   // Only moves on running falls, so a stop leaves it where it was
   always_ff @(posedge core_clk)
   begin
      if (rst)
         peripheral_clock <= 1'b1;
      else if (fall_evt)
         peripheral_clock <= !peripheral_clock;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         crystal_buffer_out <= 1'b0;
      else
         crystal_buffer_out <= crystal_s && osc_enable;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stop detection

   halt_status_s status_prev;
   logic [1:0]   trail_rises;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         status_prev <= STATUS_PASSIVE;
      else if (rise_evt)
         status_prev <= status_s;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         trail_rises <= 2'h0;
      else if (state != ST_STOP_WAIT)
         trail_rises <= 2'h0;
      else if (rise_evt)
         trail_rises <= trail_rises + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator restart counter

   logic [OSC_W-1:0] osc_count;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         osc_count <= '0;
      else if (state != ST_OSC_COUNT)
         osc_count <= '0;
      else if (crystal_rise && osc_count != OSC_FULL)
         osc_count <= osc_count + 1'b1;
   end

   // Full count waits for the request to end, so a long reset keeps clocks parked
   assign osc_done = (state == ST_OSC_COUNT) && (osc_count == OSC_FULL)
                     && reset_req_n_s;

   // A request during the trailing cycles is kept for the moment of stop
   always_ff @(posedge core_clk)
   begin
      if (rst)
         restart_pending <= 1'b0;
      else if (state == ST_STOP_WAIT && restart_req)
         restart_pending <= 1'b1;
      else if (state != ST_STOP_WAIT)
         restart_pending <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state   <= ST_STOPPED;
         osc_run <= 1'b0;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               // Same test at any clock rate, slow or fast
               if (rise_evt && status_prev == STATUS_PASSIVE
                   && status_s == STATUS_STOP)
                  state <= ST_STOP_WAIT;
            end
            ST_STOP_WAIT:
            begin
               if (rise_evt && trail_rises == STOP_TRAIL_RISES - 2'h1)
               begin
                  state <= ST_STOPPED;
                  if (!fss_s)
                     osc_run <= 1'b0;
               end
            end
            ST_STOPPED:
            begin
               if (restart_req || restart_pending)
               begin
                  if (fss_s)
                     state <= ST_RUN;
                  else
                  begin
                     state   <= ST_OSC_COUNT;
                     osc_run <= 1'b1;
                  end
               end
            end
            ST_OSC_COUNT:
            begin
               // Start requests here are ignored; a low reset request holds off osc_done; clocks stay parked high
               if (osc_done)
                  state <= ST_RUN;
            end
            default:
            begin
               state   <= ST_STOPPED;
               osc_run <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset conditioning

   logic              reset_req_cpu_n;
   logic [HOLD_W-1:0] hold_left;

   // Falling-edge resample; with clocks parked it follows the pin directly
   always_ff @(posedge core_clk)
   begin
      if (rst)
         reset_req_cpu_n <= 1'b0;
      else if (fall_evt || !run)
         reset_req_cpu_n <= reset_req_n_s;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         hold_left <= HOLD_LOAD;
      else if (!reset_req_cpu_n)
         hold_left <= HOLD_LOAD;
      else if (osc_done && cpu_reset_out)
         hold_left <= HOLD_LOAD;
      else if (fall_evt && hold_left != '0)
         hold_left <= hold_left - HOLD_ONE;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         cpu_reset_out <= 1'b1;
      else if (!reset_req_cpu_n)
         cpu_reset_out <= 1'b1;
      else if (fall_evt && hold_left == HOLD_ONE && !osc_done)
         cpu_reset_out <= 1'b0;
   end

endmodule

// >>> test/clock_stop_start_assertions.sv
// Purpose: Port checker for the clock stop/start/reset block
// Assumes: Source levels last at least three core clocks
// Notes:   Small counters stand in for long waits
`timescale 1ns/10ps
module clock_stop_start_assertions
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reset_request_n,
   input wire logic freq_source_select,
   input wire logic cpu_clock,
   input wire logic half_duty_clock,
   input wire logic peripheral_clock,
   input wire logic crystal_buffer_out,
   input wire logic osc_enable,
   input wire logic cpu_reset_out
);
   logic [5:0] low_run;
   logic [5:0] cpu_low;
   logic [4:0] falls;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk)
   begin
      if (rst || reset_request_n)
         low_run <= 6'h0;
      else if (low_run != 6'h3f)
         low_run <= low_run + 6'h1;
   end
   always_ff @(posedge core_clk)
   begin
      if (rst || cpu_clock)
         cpu_low <= 6'h0;
      else if (cpu_low != 6'h3f)
         cpu_low <= cpu_low + 6'h1;
   end
   // Falls since the request went away; saturates so it never wraps
   always_ff @(posedge core_clk)
   begin
      if (rst || !reset_request_n)
         falls <= 5'h0;
      else if ($fell(cpu_clock) && falls != 5'h1f)
         falls <= falls + 5'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_reset_rises:
   assert property ($fell(reset_request_n) ##1 !reset_request_n [*8] |-> ##[0:40] cpu_reset_out)
      else $error("reset output did not follow request");
   chk_reset_kept:
   assert property (low_run == 6'h3f |-> cpu_reset_out) else $error("reset output dropped");
   chk_reset_hold:
   // Reset output leads its own clock fall by one core clock, counter lags one more
   assert property ($fell(cpu_reset_out) |-> ##2 falls >= 5'd16)
      else $error("reset released early");
   chk_halt_high:
   assert property (cpu_low < 6'd40) else $error("processor clock parked low");
   chk_duty_pair:
   assert property (cpu_clock |-> half_duty_clock) else $error("clock phase broken");
   chk_fall_align:
   assert property ($fell(half_duty_clock) |-> $fell(cpu_clock)) else $error("falls not aligned");
   chk_pclk_steps:
   assert property ($changed(peripheral_clock) |=> $fell(cpu_clock))
      else $error("peripheral clock moved alone");
   chk_efi_osc_on:
   assert property (freq_source_select [*4] |-> osc_enable) else $error("oscillator off");
   chk_crystal_gate:
   assert property (!osc_enable |=> !crystal_buffer_out) else $error("oscillator output leaks");
   chk_count_first:
   assert property ($fell(cpu_clock) && !freq_source_select |-> osc_enable)
      else $error("clock runs without oscillator");
endmodule

bind clock_stop_start clock_stop_start_assertions checker_inst
(
   .core_clk           (core_clk),
   .rst                (rst),
   .reset_request_n    (reset_request_n),
   .freq_source_select (freq_source_select),
   .cpu_clock          (cpu_clock),
   .half_duty_clock    (half_duty_clock),
   .peripheral_clock   (peripheral_clock),
   .crystal_buffer_out (crystal_buffer_out),
   .osc_enable         (osc_enable),
   .cpu_reset_out      (cpu_reset_out)
);

// >>> test/cpu_status_model.sv
// Purpose: Processor status lines as seen by the clock block
// Assumes: Status moves only just after a processor clock fall
// Notes:   One request gives a lead-in code, the stop code, then passive
`timescale 1ns/10ps
module cpu_status_model
   import clock_ctl_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         cpu_clock,
   input  wire logic         halt_req,
   input  wire halt_status_s pre_code,
   output halt_status_s      status
);
   logic [1:0] step;
   logic       last_clk;
   initial
   begin
      step = 2'h0;
      last_clk = 1'b1;
      status = STATUS_PASSIVE;
   end
   // Changing at the fall keeps the code steady around each rise
   always @(negedge core_clk)
   begin
      last_clk <= cpu_clock;
      if (halt_req)
         step <= 2'h1;
      else if (last_clk && !cpu_clock && step != 2'h0)
      begin
         step <= step + 2'h1;
         if (step == 2'h1)
            status <= pre_code;
         else if (step == 2'h2)
            status <= STATUS_STOP;
         else
            status <= STATUS_PASSIVE;
      end
   end
endmodule

// >>> test/clock_stop_start_tb.sv
// Purpose: Self-checking bench for the clock stop/start/reset block
// Assumes: Restart count shortened to sixteen oscillator rises
// Notes:   Crystal only toggles while the oscillator is enabled
`timescale 1ns/10ps
module clock_stop_start_tb
   import clock_ctl_pkg::*;
;
   typedef struct packed {logic fss; logic by_reset; logic [8:0] lo; logic [8:0] hi;} row_s;
   logic         core_clk, rst, reset_request_n, start, freq_source_select, halt_req;
   logic         crystal_in, external_freq_input, cpu_clock, half_duty_clock;
   logic         peripheral_clock, crystal_buffer_out, osc_enable, cpu_reset_out;
   logic [1:0]   src_div;
   halt_status_s pre_code, status;
   int           failures, n_checks, cyc, fall_gap;
   row_s         rows [4] = '{'{1'b1, 1'b1, 9'h4, 9'h3c}, '{1'b0, 1'b0, 9'h78, 9'h190},
                              '{1'b0, 1'b1, 9'h78, 9'h190}, '{1'b1, 1'b0, 9'h4, 9'h3c}};
   ////////////////////////////////////////////////////////////////////////////////
   clock_stop_start #(.OSC_START_COUNT(16)) DUT
   (
      .core_clk (core_clk), .rst (rst), .reset_request_n (reset_request_n), .start (start),
      .freq_source_select (freq_source_select), .crystal_in (crystal_in),
      .external_freq_input (external_freq_input), .halt_status_or_stop_n (status.stop_n),
      .halt_status_mid (status.mid), .halt_status_low (status.low), .cpu_clock (cpu_clock),
      .half_duty_clock (half_duty_clock), .peripheral_clock (peripheral_clock),
      .crystal_buffer_out (crystal_buffer_out), .osc_enable (osc_enable),
      .cpu_reset_out (cpu_reset_out)
   );
   cpu_status_model partner
   (
      .core_clk (core_clk), .cpu_clock (cpu_clock), .halt_req (halt_req),
      .pre_code (pre_code), .status (status)
   );
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // A stopped crystal stops toggling, like the real part
   always @(negedge core_clk)
   begin
      src_div <= src_div + 2'h1;
      if (src_div == 2'h3)
      begin
         external_freq_input <= ~external_freq_input;
         if (osc_enable)
            crystal_in <= ~crystal_in;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(string name, logic seen, logic exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic wait_fall(int bound, output int n);
      logic prev;
      n = 0;
      prev = cpu_clock;
      while (!(prev === 1'b1 && cpu_clock === 1'b0))
      begin
         prev = cpu_clock;
         @(negedge core_clk);
         n++;
         if (n > bound)
         begin
            failures++;
            give_verdict();
         end
      end
   endtask
   // Request pulse, then the delay to the first processor clock fall
   task automatic restart(logic by_reset, int lo, int hi);
      if (by_reset)
         reset_request_n = 1'b0;
      else
         start = 1'b1;
      repeat (10) @(negedge core_clk);
      start = 1'b0;
      reset_request_n = 1'b1;
      wait_fall(hi, cyc);
      check("restart delay", cyc + 10 >= lo, 1'b1);
   endtask
   task automatic halt(halt_status_s pre, logic expect_stop);
      logic moved;
      logic pclk;
      pre_code = pre;
      halt_req = 1'b1;
      @(negedge core_clk);
      halt_req = 1'b0;
      repeat (200) @(negedge core_clk);
      moved = 1'b0;
      pclk = peripheral_clock;
      repeat (60)
      begin
         @(negedge core_clk);
         moved = moved | !cpu_clock | (peripheral_clock !== pclk);
      end
      check("clock stopped", !moved, expect_stop);
      if (expect_stop)
      begin
         check("half duty high", half_duty_clock, 1'b1);
         check("oscillator run", osc_enable, freq_source_select);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, start, halt_req, crystal_in, external_freq_input} = 5'h10;
      {reset_request_n, freq_source_select, src_div} = 4'hc;
      {failures, n_checks, pre_code} = {32'h0, 32'h0, STATUS_PASSIVE};
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      check("parked high", cpu_clock, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         freq_source_select = rows[i].fss;
         repeat (5) @(negedge core_clk);
         restart(rows[i].by_reset, rows[i].lo, rows[i].hi);
         halt(STATUS_PASSIVE, 1'b1);
      end
      restart(1'b0, 4, 60);
      cyc = 0;
      while (cpu_reset_out === 1'b1 && cyc < 20)
      begin
         wait_fall(40, fall_gap);
         cyc++;
      end
      check("reset released", cpu_reset_out, 1'b0);
      halt(3'h6, 1'b0);
      reset_request_n = 1'b0;
      repeat (100) @(negedge core_clk);
      check("reset output", cpu_reset_out, 1'b1);
      reset_request_n = 1'b1;
      cyc = 0;
      while (cpu_reset_out === 1'b1 && cyc < 30)
      begin
         wait_fall(40, fall_gap);
         cyc++;
      end
      check("reset length", cyc >= 16 && cyc <= 18, 1'b1);
      halt(STATUS_PASSIVE, 1'b1);
      freq_source_select = 1'b0;
      repeat (5) @(negedge core_clk);
      start = 1'b1;
      repeat (10) @(negedge core_clk);
      start = 1'b0;
      repeat (50) @(negedge core_clk);
      restart(1'b1, 60, 300);
      check("count kept", cyc + 70 < 185, 1'b1);
      give_verdict();
   end
endmodule
